// *** core/hcs_params.svh ***
`ifndef HCS_PARAMS_SVH
`define HCS_PARAMS_SVH

// ==========================================================
// register map
`define HCS_CFG_OFFSET      30'h0000_0000
`define HCS_CFG_RESET       16'h0000
`define HCS_CFG_WIDTH       16

// ==========================================================
// field positions
`define HCS_THR_BIT         4
`define HCS_INORDER_QUEUE_DEPTH_FLAG_BIT        2
`define HCS_SEL_BIT         1

// ==========================================================
// in-order queue depths
`define HCS_IOQ_DEEP        4'hC
`define HCS_IOQ_SHALLOW     4'h1
`define HCS_INORDER_QUEUE_DEPTH_FLAG_RESET      1'b0

// ==========================================================
// interrupt controller windows
`define HCS_WIN_A_LO        36'h0_FEC0_0000
`define HCS_WIN_A_HI        36'h0_FEC7_FFFF
`define HCS_WIN_LINK_BASE   36'h0_FEC8_0000
`define HCS_WIN_LINK_SPAN   36'h0_0000_1000

`endif

// *** core/hcs_pkg.sv ***
package hcs_pkg;

	// ==========================================================
	// types
	typedef logic [35:0] hcs_addr_t;

	typedef enum logic [1:0] {
		HCS_LINK_A,
		HCS_LINK_B,
		HCS_LINK_C,
		HCS_LINK_D
	} hcs_link_t;

	typedef enum logic {
		HCS_BUS_HELD,
		HCS_BUS_RUN
	} hcs_bus_state_t;

endpackage

// *** core/hcs_route_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface hcs_route_if;
	import hcs_pkg::*;

	hcs_addr_t addr;
	logic      range_sel;
	hcs_link_t cfg_link;
	logic      hit;
	hcs_link_t link;

	modport ctrl (
		output addr,
		output range_sel,
		output cfg_link,
		input  hit,
		input  link
	);

	modport route (
		input  addr,
		input  range_sel,
		input  cfg_link,
		output hit,
		output link
	);
endinterface

`default_nettype wire

// *** core/hcs_route.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hcs_params.svh"

module hcs_route (
	// clock and reset, for checks only
	input wire logic   hclk,
	input wire logic   hresetn,
	// decode request and answer
	hcs_route_if.route rt
);
	import hcs_pkg::*;

	// ==========================================================
	// fixed windows
	logic       win_a;
	logic [2:0] win_bcd;

	assign win_a = (rt.addr >= `HCS_WIN_A_LO) && (rt.addr <= `HCS_WIN_A_HI);

	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_win
			localparam hcs_addr_t LO = `HCS_WIN_LINK_BASE
				+ hcs_addr_t'(i) * `HCS_WIN_LINK_SPAN;
			assign win_bcd[i] = (rt.addr >= LO)
				&& (rt.addr < LO + `HCS_WIN_LINK_SPAN);
		end
	endgenerate

	// ==========================================================
	// selection
	hcs_link_t fixed_link;

	assign fixed_link = win_bcd[0] ? HCS_LINK_B :
		win_bcd[1] ? HCS_LINK_C :
		win_bcd[2] ? HCS_LINK_D : HCS_LINK_A;
	assign rt.hit  = win_a | (|win_bcd);
	assign rt.link = rt.range_sel ? rt.cfg_link : fixed_link;

	// ==========================================================
	// checks
	win_a_route_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!rt.range_sel && rt.addr[35:19] == 17'h0_FEC0 >> 3
		|-> rt.hit && rt.link == HCS_LINK_A)
		else $error("window a not routed to link a");
	win_b_route_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!rt.range_sel && rt.addr[35:12] == 24'h0F_EC80
		|-> rt.hit && rt.link == HCS_LINK_B)
		else $error("window b not routed to link b");
	win_c_route_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!rt.range_sel && rt.addr[35:12] == 24'h0F_EC81
		|-> rt.hit && rt.link == HCS_LINK_C)
		else $error("window c not routed to link c");
	win_d_route_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!rt.range_sel && rt.addr[35:12] == 24'h0F_EC82
		|-> rt.hit && rt.link == HCS_LINK_D)
		else $error("window d not routed to link d");
	cfg_route_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		rt.range_sel && rt.hit |-> rt.link == rt.cfg_link)
		else $error("config routing ignored");
endmodule

`default_nettype wire

// *** core/hcs_strap.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hcs_params.svh"

module hcs_strap (
	// clock and reset
	input wire logic  hclk,
	input wire logic  hresetn,
	input wire logic  ce,
	// processor bus pins
	input wire logic  processor_bus_reset_n,
	input wire logic  host_addr_strap_bit_n,
	// captured result
	output logic      inorder_queue_depth_flag_q,
	output logic [3:0] ioq_depth_q
);
	import hcs_pkg::*;

	// ==========================================================
	// release detect and capture
	hcs_bus_state_t state_q;
	hcs_bus_state_t state_d;
	logic           release_w;

	assign release_w = (state_q == HCS_BUS_HELD) && processor_bus_reset_n;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			HCS_BUS_HELD: if (processor_bus_reset_n) state_d = HCS_BUS_RUN;
			HCS_BUS_RUN:  if (!processor_bus_reset_n) state_d = HCS_BUS_HELD;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q     <= HCS_BUS_HELD;
			inorder_queue_depth_flag_q      <= `HCS_INORDER_QUEUE_DEPTH_FLAG_RESET;
			ioq_depth_q <= `HCS_IOQ_SHALLOW;
		end else if (ce) begin
			state_q <= state_d;
			if (release_w) begin
				inorder_queue_depth_flag_q      <= !host_addr_strap_bit_n;
				ioq_depth_q <= host_addr_strap_bit_n ?
					`HCS_IOQ_SHALLOW : `HCS_IOQ_DEEP;
			end
		end
	end

	// ==========================================================
	// checks
	strap_low_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ce && release_w && !host_addr_strap_bit_n
		|=> inorder_queue_depth_flag_q && ioq_depth_q == 4'hC)
		else $error("low strap not captured as deep queue");
	strap_high_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ce && release_w && host_addr_strap_bit_n
		|=> !inorder_queue_depth_flag_q && ioq_depth_q == 4'h1)
		else $error("high strap not captured as depth one");
	strap_hold_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!(ce && release_w) |=> $stable(inorder_queue_depth_flag_q))
		else $error("queue depth changed outside release");
endmodule

`default_nettype wire

// *** core/hcs_top.sv ***
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "hcs_params.svh"
// Functional notes
// - set throttle flag on exhausted slice with pending
// - throttle flag sticks until written zero
// - capture strap at processor reset release
// - strap low: field reads one, depth twelve
// - strap high: field reads zero, depth one
// - range control zero: first window to link a
// - range control zero: next window to link b
// - range control zero: next window to link c
// - range control zero: next window to link d
// - range control one: configured link instead

module hcs_top (
	// clock and reset
	input wire logic         hclk,
	input wire logic         hresetn,
	input wire logic         ce,
	// ahb-lite slave
	input wire logic         hsel,
	input wire logic [31:0]  haddr,
	input wire logic [1:0]   htrans,
	input wire logic         hwrite,
	input wire logic [2:0]   hsize,
	input wire logic [31:0]  hwdata,
	input wire logic         hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// processor bus
	input wire logic         processor_bus_reset_n,
	input wire logic         host_addr_strap_bit_n,
	input wire logic         host_addr_valid,
	input wire hcs_pkg::hcs_addr_t host_addr,
	// write throttle engine
	input wire logic         slice_writes_exhausted,
	input wire logic         write_pending,
	// bridge configuration decode
	input wire hcs_pkg::hcs_link_t cfg_apic_link,
	// routing and queue results
	output logic             route_valid,
	output hcs_pkg::hcs_link_t route_link,
	output logic [3:0]       ioq_depth,
	output logic             intr_ctrl_range_select
);
	import hcs_pkg::*;

	// ==========================================================
	// bus address phase
	logic        addr_take;
	logic        reg_hit;
	logic        lane0;
	logic        wr_q;
	logic        wr_hit_q;
	logic        wr_apply;

	assign addr_take = hsel && hready && htrans[1];
	assign reg_hit   = haddr[31:2] == `HCS_CFG_OFFSET;
	assign lane0     = (hsize == 3'h2) || (haddr[1:0] == 2'h0);
	assign wr_apply  = wr_q && wr_hit_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q     <= 1'b0;
			wr_hit_q <= 1'b0;
		end else if (ce) begin
			wr_q     <= addr_take && hwrite;
			wr_hit_q <= addr_take && hwrite && reg_hit && lane0;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ==========================================================
	// configuration register
	logic        thr_q;
	logic        thr_d;
	logic        thr_set;
	logic        thr_clr;
	logic        sel_q;
	logic        sel_d;
	logic        inorder_queue_depth_flag;
	logic [15:0] cfg_rd;

	assign thr_set = slice_writes_exhausted && write_pending;
	assign thr_clr = wr_apply && !hwdata[`HCS_THR_BIT];
	assign thr_d   = thr_set || (thr_q && !thr_clr);
	assign sel_d   = wr_apply ? hwdata[`HCS_SEL_BIT] : sel_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			thr_q <= 1'(`HCS_CFG_RESET >> `HCS_THR_BIT);
			sel_q <= 1'(`HCS_CFG_RESET >> `HCS_SEL_BIT);
		end else if (ce) begin
			thr_q <= thr_d;
			sel_q <= sel_d;
		end
	end

	always_comb begin
		cfg_rd                = 16'h0000;
		cfg_rd[`HCS_THR_BIT]  = thr_q;
		cfg_rd[`HCS_INORDER_QUEUE_DEPTH_FLAG_BIT] = inorder_queue_depth_flag;
		cfg_rd[`HCS_SEL_BIT]  = sel_q;
	end

	// ==========================================================
	// read data
	logic [31:0] rdata_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (ce && addr_take && !hwrite) begin
			rdata_q <= reg_hit ? {16'h0000, cfg_rd} : 32'h0000_0000;
		end
	end

	assign hrdata                 = rdata_q;
	assign intr_ctrl_range_select = sel_q;

	// ==========================================================
	// strap capture
	hcs_strap u_strap (
		.hclk                  (hclk),
		.hresetn               (hresetn),
		.ce                    (ce),
		.processor_bus_reset_n (processor_bus_reset_n),
		.host_addr_strap_bit_n (host_addr_strap_bit_n),
		.inorder_queue_depth_flag_q                (inorder_queue_depth_flag),
		.ioq_depth_q           (ioq_depth)
	);

	// ==========================================================
	// window routing
	hcs_route_if rt ();

	assign rt.addr      = host_addr;
	assign rt.range_sel = sel_q;
	assign rt.cfg_link  = cfg_apic_link;

	hcs_route u_route (
		.hclk    (hclk),
		.hresetn (hresetn),
		.rt      (rt)
	);

	logic      route_valid_q;
	hcs_link_t route_link_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			route_valid_q <= 1'b0;
			route_link_q  <= HCS_LINK_A;
		end else if (ce) begin
			route_valid_q <= host_addr_valid && rt.hit;
			route_link_q  <= rt.link;
		end
	end

	assign route_valid = route_valid_q;
	assign route_link  = route_link_q;

	// ==========================================================
	// checks
	thr_sets_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ce && slice_writes_exhausted && write_pending |=> thr_q)
		else $error("throttle event did not set flag");
	thr_sticks_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		thr_q && !(ce && wr_apply) |=> thr_q)
		else $error("throttle flag dropped without a write");
	thr_clears_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ce && wr_apply && !hwdata[4] && !thr_set |=> !thr_q)
		else $error("write of zero did not clear flag");
	thr_one_keeps_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ce && wr_apply && hwdata[4] |=> thr_q == $past(thr_q) || $past(thr_set))
		else $error("write of one changed flag");
	sel_write_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ce && wr_apply |=> sel_q == $past(hwdata[1]))
		else $error("range control not written");
	read_back_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ce && addr_take && !hwrite && reg_hit
		|=> hrdata == {27'h0, $past(thr_q), 1'b0, $past(inorder_queue_depth_flag),
		$past(sel_q), 1'b0})
		else $error("register read back wrong");
	inorder_queue_depth_flag_ro_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ce && wr_apply && processor_bus_reset_n
		&& $past(processor_bus_reset_n) |=> $stable(inorder_queue_depth_flag))
		else $error("write altered queue depth field");
	depth_match_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ioq_depth == (inorder_queue_depth_flag ? 4'hC : 4'h1))
		else $error("queue depth disagrees with field");
	route_reg_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ce && host_addr_valid && rt.hit |=> route_valid
		&& route_link == $past(rt.link))
		else $error("route result not registered");
endmodule

`default_nettype wire

// *** bench/hcs_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module hcs_host_model (
	// clock
	input wire logic               hclk,
	// processor bus pins
	output var logic               processor_bus_reset_n,
	output var logic               host_addr_strap_bit_n,
	output var logic               host_addr_valid,
	output var hcs_pkg::hcs_addr_t host_addr
);
	import hcs_pkg::*;

	initial begin
		processor_bus_reset_n = 1'b0;
		host_addr_strap_bit_n = 1'b1;
		host_addr_valid = 1'b0;
		host_addr = 36'h0_0000_0000;
	end

	// ==========================================================
	// bus reset pulse, strap only valid around the release
	task automatic release_reset(input logic strap_n);
		processor_bus_reset_n <= 1'b0;
		repeat (2) @(posedge hclk);
		host_addr_strap_bit_n <= strap_n;
		@(posedge hclk);
		processor_bus_reset_n <= 1'b1;
		@(posedge hclk);
		host_addr_strap_bit_n <= ~strap_n;
	endtask

	// ==========================================================
	// one host cycle; an idle address is scrambled
	task automatic cycle(input hcs_addr_t a, input logic v);
		host_addr_valid <= v;
		host_addr <= v ? a : ~a;
		@(posedge hclk);
	endtask
endmodule

`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import hcs_pkg::*;

	// ==========================================================
	// signals
	logic        hclk;
	logic        hresetn;
	logic        ce;
	logic        hsel;
	logic        hwrite;
	logic        hready;
	logic        hreadyout;
	logic        hresp;
	logic        host_addr_valid;
	logic        slice_writes_exhausted;
	logic        write_pending;
	logic        route_valid;
	logic        processor_bus_reset_n;
	logic        host_addr_strap_bit_n;
	logic        intr_ctrl_range_select;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  ioq_depth;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [2:0]  e;
	logic        v;
	logic        sel_e;
	logic        thr_e;
	logic        inorder_queue_depth_flag_e;
	hcs_addr_t   host_addr;
	hcs_addr_t   a;
	hcs_link_t   c;
	hcs_link_t   cfg_apic_link;
	hcs_link_t   route_link;
	int          n_errors;
	int          cmp_count;
	int          cycles;
	hcs_addr_t   corner [10] = '{36'h0_FEBF_FFFF, 36'h0_FEC0_0000,
		36'h0_FEC7_FFFF, 36'h0_FEC8_0000, 36'h0_FEC8_0FFF, 36'h0_FEC8_1000,
		36'h0_FEC8_1FFF, 36'h0_FEC8_2000, 36'h0_FEC8_2FFF, 36'h0_FEC8_3000};

	assign hready = hreadyout;

	hcs_top uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata),
		.processor_bus_reset_n(processor_bus_reset_n),
		.host_addr_strap_bit_n(host_addr_strap_bit_n),
		.host_addr_valid(host_addr_valid), .host_addr(host_addr),
		.slice_writes_exhausted(slice_writes_exhausted),
		.write_pending(write_pending), .cfg_apic_link(cfg_apic_link),
		.route_valid(route_valid), .route_link(route_link),
		.ioq_depth(ioq_depth),
		.intr_ctrl_range_select(intr_ctrl_range_select));

	hcs_host_model model (.hclk(hclk),
		.processor_bus_reset_n(processor_bus_reset_n),
		.host_addr_strap_bit_n(host_addr_strap_bit_n),
		.host_addr_valid(host_addr_valid), .host_addr(host_addr));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 2000) begin
			n_errors++;
			stop_test();
		end
	end

	// ==========================================================
	// expectations
	function automatic logic [31:0] reg_exp();
		return {27'h0, thr_e, 1'b0, inorder_queue_depth_flag_e, sel_e, 1'b0};
	endfunction

	function automatic logic [2:0] route_exp(hcs_addr_t x, logic ok,
		logic s, hcs_link_t cl);
		hcs_addr_t  off;
		logic [1:0] l;
		logic       h;
		off = x - 36'h0_FEC8_0000;
		h = 1'b1;
		l = 2'h0;
		if (x >= 36'h0_FEC0_0000 && x <= 36'h0_FEC7_FFFF)
			l = 2'h0;
		else if (off < 36'h0_0000_3000)
			l = off[13:12] + 2'h1;
		else
			h = 1'b0;
		if (s)
			l = cl;
		return {ok & h, l};
	endfunction

	// ==========================================================
	// bus and compare helpers
	task automatic ahb(input logic w, input logic [31:0] ad, wd);
		hsel <= 1'b1;
		haddr <= ad;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic chk(input logic [31:0] got, want);
		cmp_count++;
		if (got !== want) begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, want);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(32'h8e67));
		{hresetn, hsel, hwrite, slice_writes_exhausted, write_pending} = 0;
		{haddr, hwdata, htrans, cycles, n_errors, cmp_count} = 0;
		{sel_e, thr_e, inorder_queue_depth_flag_e} = 0;
		ce = 1'b1;
		hsize = 3'h2;
		cfg_apic_link = HCS_LINK_A;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 2; i++) begin
			model.release_reset(~i[0]);
			inorder_queue_depth_flag_e = i[0];
			ahb(1'b0, 32'h0, 32'h0);
			chk(rd, reg_exp());
			chk(32'(ioq_depth), i[0] ? 32'hC : 32'h1);
		end
		ahb(1'b1, 32'h0, 32'hFFFF_FFFF);
		sel_e = 1'b1;
		ahb(1'b0, 32'h0, 32'h0);
		chk(rd, reg_exp());
		chk(32'(intr_ctrl_range_select), 32'h1);
		ahb(1'b1, 32'h0, 32'h0);
		ahb(1'b1, 32'h4, 32'h2);
		sel_e = 1'b0;
		ahb(1'b0, 32'h4, 32'h0);
		chk(rd, 32'h0);
		ahb(1'b0, 32'h0, 32'h0);
		chk(rd, reg_exp());
		for (int i = 1; i < 4; i++) begin
			slice_writes_exhausted <= i[0];
			write_pending <= i[1];
			@(posedge hclk);
			slice_writes_exhausted <= 1'b0;
			write_pending <= 1'b0;
			thr_e = (i == 3);
			ahb(1'b0, 32'h0, 32'h0);
			chk(rd, reg_exp());
		end
		ahb(1'b1, 32'h0, 32'h10);
		ahb(1'b0, 32'h0, 32'h0);
		chk(rd, reg_exp());
		ahb(1'b1, 32'h0, 32'h0);
		thr_e = 1'b0;
		ahb(1'b0, 32'h0, 32'h0);
		chk(rd, reg_exp());
		// frozen clock enable must swallow a throttle event
		ce <= 1'b0;
		slice_writes_exhausted <= 1'b1;
		write_pending <= 1'b1;
		repeat (2) @(posedge hclk);
		slice_writes_exhausted <= 1'b0;
		write_pending <= 1'b0;
		ce <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, 32'h0, 32'h0);
		chk(rd, reg_exp());
		for (int s = 0; s < 2; s++) begin
			ahb(1'b1, 32'h0, {30'h0, s[0], 1'b0});
			for (int i = 0; i < 40; i++) begin
				if (i < 10)
					a = corner[i];
				else if ($urandom % 2)
					a = {4'h0, 16'hFEC8, 16'($urandom)};
				else
					a = {4'h0, 12'hFEC, 20'($urandom)};
				v = (i < 10) || ($urandom % 4 != 0);
				c = hcs_link_t'(2'($urandom));
				cfg_apic_link <= c;
				model.cycle(a, v);
				#1;
				e = route_exp(a, v, s[0], c);
				chk(32'(route_valid), 32'(e[2]));
				if (e[2])
					chk(32'(route_link), 32'(e[1:0]));
			end
		end
		stop_test();
	end
endmodule

`default_nettype wire
